// *** verilog/core_cfg.svh ***
// Purpose: Constants for the instruction cycle core
// Assumes: 16-bit instruction words, 8-bit data, 11-bit program counter
// Notes:   Encodings are local to this core
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH

// ==========================================
// Timing
`define PHASES_PER_CYCLE 4
`define PH_FETCH         2'd0
`define PH_ADDR          2'd1
`define PH_READ          2'd2
`define PH_EXEC          2'd3

// ==========================================
// Major opcodes, bits 15:12
`define OP_ALU_ACC  4'h0
`define OP_ALU_MEM  4'h1
`define OP_LOAD_IMM  4'h2
`define OP_ADD_IMM  4'h3
`define OP_SUB_IMM  4'h4
`define OP_STORE_ACC 4'h5
`define OP_BIT_SET  4'h6
`define OP_BIT_CLR  4'h7
`define OP_SKIP_Z   4'h8
`define OP_SKIP_BZ  4'h9
`define OP_SKIP_BNZ 4'ha
`define OP_JUMP     4'hb
`define OP_CALL     4'hc
`define OP_RETURN     4'hd
`define OP_INT_RETURN 4'he
`define OP_TAB_RD   4'hf

// ==========================================
// ALU sub-operations, bits 11:8
`define ALU_MOVE 4'h0
`define ALU_ADD  4'h1
`define ALU_SUB  4'h2
`define ALU_AND  4'h3
`define ALU_OR   4'h4
`define ALU_XOR  4'h5
`define ALU_INVERT 4'h6
`define ALU_INC    4'h7
`define ALU_DECR   4'h8
`define ALU_ROT_R  4'h9
`define ALU_ROT_L  4'ha
`define ALU_ROT_RC 4'hb
`define ALU_ROT_LC 4'hc

// ==========================================
// Addresses and reset values
`define PC_LOW_ADDR 8'h06
`define TBL_PAGE   3'h7
`define PC_RESET   11'h000
`define ACC_RESET  8'h00

`endif

// *** verilog/core_pkg.sv ***
// Purpose: Types for the instruction cycle core
// Assumes: Constants live in core_cfg.svh
// Notes:   Types only
package core_pkg;

  typedef logic [10:0] pc_t;
  typedef logic [7:0]  byte_t;

  // Normal cycle, or the added cycle of a two-cycle instruction
  typedef enum logic {
    CYC_EXEC,
    CYC_EXTRA
  } cyc_e;

endpackage : core_pkg

// *** verilog/instr_cycle_core.sv ***
// Purpose: 8-bit core with four-clock instruction cycles
// Assumes: Program and data memory answer combinationally on clk
// Notes:   No prefetch; the added cycle fetches one word and drops it, except table read, which keeps its low byte
//
// How it works
// - Each instruction cycle is four clock periods long.
// - Ordinary instructions finish in one instruction cycle.
// - Jump, call, both returns and table read take two cycles.
// - Writing the program counter low byte adds one cycle.
// - A write to the program counter low byte jumps to the new address, except a table read aimed there, which is dropped.
// - A skip costs one cycle, plus one more when it skips.
// - Add sets carry above 255 and subtract sets borrow below 0.
// - Increment and decrement change the value by one into memory or accumulator.
// - Logic operations set the zero flag on a zero result.
// - Rotates shift one bit, and the via-carry forms move the dropped bit to carry.
// - Moves go register to accumulator, accumulator to register, or immediate to accumulator.
// - Call saves the return point, return resumes after the call, jump saves nothing.
// - A conditional skip tests a byte or a bit and runs or skips the next instruction.
// - Bit set and clear rewrite the byte changing only the chosen bit.
// - Table read fetches a constant from program memory into data memory.
`timescale 1ns/10ps
`include "core_cfg.svh"

module instr_cycle_core
  import core_pkg::*;
#(
  parameter int STACK_DEPTH = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // Program memory
  output logic       [10:0] pm_addr_ff,
  input  wire logic  [15:0] pm_data,
  // Data memory
  output logic       [7:0]  dm_addr_ff,
  output logic       [7:0]  dm_wdata_ff,
  output logic              dm_we_ff,
  input  wire logic  [7:0]  dm_rdata,
  // Status
  output logic       [1:0]  phase_ff,
  output logic              retire_ff,
  output logic       [7:0]  acc_ff,
  output logic              zero_ff,
  output logic              carry_ff
);

  localparam int SPW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  // ==========================================
  // ALU
  // Result layout: {carry out, carry used, zero used, value}
  function automatic logic [10:0] alu(input logic [3:0] op, input byte_t a,
                                      input byte_t m, input logic c);
    logic [8:0] wide;
    wide = 9'h000;
    unique case (op)
      `ALU_MOVE: alu = {3'b000, m};
      `ALU_ADD: begin
        wide = {1'b0, a} + {1'b0, m};
        alu  = {wide[8], 2'b11, wide[7:0]};
      end
      `ALU_SUB: begin
        wide = {1'b0, a} - {1'b0, m};
        alu  = {wide[8], 2'b11, wide[7:0]};
      end
      `ALU_AND: alu = {3'b001, a & m};
      `ALU_OR:  alu = {3'b001, a | m};
      `ALU_XOR: alu = {3'b001, a ^ m};
      `ALU_INVERT: alu = {3'b001, ~m};
      `ALU_INC:    alu = {3'b001, m + 8'h01};
      `ALU_DECR:   alu = {3'b001, m - 8'h01};
      `ALU_ROT_R:  alu = {3'b000, m[0], m[7:1]};
      `ALU_ROT_L:  alu = {3'b000, m[6:0], m[7]};
      `ALU_ROT_RC: alu = {m[0], 2'b10, c, m[7:1]};
      `ALU_ROT_LC: alu = {m[7], 2'b10, m[6:0], c};
      default:  alu = {3'b000, a};                           // Unused codes pass the accumulator through as the result
    endcase
  endfunction : alu

  // ==========================================
  // State
  cyc_e        cyc_ff;
  pc_t         pc_ff;
  pc_t         target_ff;
  logic [15:0] ir_ff;
  byte_t       operand_ff;
  logic        tab_ff;
  logic [SPW-1:0] sp_ff;
  pc_t         stack_mem [STACK_DEPTH];

  // ==========================================
  // Decode, evaluated for the execute phase
  logic [3:0]  opc;
  logic [3:0]  sub;
  byte_t       mfield;
  logic [2:0]  bidx;
  logic [10:0] alu_out;
  byte_t       nxt_res;
  logic        nxt_wr_acc;
  logic        nxt_wr_mem;
  logic        nxt_two;
  logic        nxt_push;
  logic        nxt_pop;
  logic        nxt_tab;
  logic        nxt_flags;
  pc_t         nxt_target;
  pc_t         pc_inc;

  always_comb begin
    opc        = ir_ff[15:12];
    sub        = ir_ff[11:8];
    mfield     = ir_ff[7:0];
    bidx       = ir_ff[10:8];
    pc_inc     = pc_ff + 11'd1;
    alu_out    = alu(sub, acc_ff, operand_ff, carry_ff);
    nxt_res    = alu_out[7:0];
    nxt_flags  = 1'b1;
    nxt_wr_acc = 1'b0;
    nxt_wr_mem = 1'b0;
    nxt_two    = 1'b0;
    nxt_push   = 1'b0;
    nxt_pop    = 1'b0;
    nxt_tab    = 1'b0;
    nxt_target = pc_inc;
    unique case (opc)
      `OP_ALU_ACC: nxt_wr_acc = 1'b1;
      `OP_ALU_MEM: nxt_wr_mem = 1'b1;
      `OP_LOAD_IMM, `OP_ADD_IMM, `OP_SUB_IMM: begin
        alu_out    = alu((opc == `OP_LOAD_IMM) ? `ALU_MOVE :
                         (opc == `OP_ADD_IMM) ? `ALU_ADD : `ALU_SUB,
                         acc_ff, mfield, carry_ff);
        nxt_res    = alu_out[7:0];
        nxt_wr_acc = 1'b1;
      end
      `OP_STORE_ACC: begin
        nxt_res    = acc_ff;
        nxt_wr_mem = 1'b1;
        nxt_flags  = 1'b0;
      end
      `OP_BIT_SET, `OP_BIT_CLR: begin
        nxt_res       = operand_ff;
        nxt_res[bidx] = (opc == `OP_BIT_SET);
        nxt_wr_mem    = 1'b1;
        nxt_flags     = 1'b0;
      end
      `OP_SKIP_Z, `OP_SKIP_BZ, `OP_SKIP_BNZ: begin
        nxt_flags = 1'b0;
        if ((opc == `OP_SKIP_Z   && operand_ff == 8'h00) ||
            (opc == `OP_SKIP_BZ  && !operand_ff[bidx]) ||
            (opc == `OP_SKIP_BNZ &&  operand_ff[bidx])) begin
          nxt_two    = 1'b1;
          nxt_target = pc_ff + 11'd2;
        end
      end
      `OP_JUMP: begin
        nxt_flags  = 1'b0;
        nxt_two    = 1'b1;
        nxt_target = ir_ff[10:0];
      end
      `OP_CALL: begin
        nxt_flags  = 1'b0;
        nxt_two    = 1'b1;
        nxt_push   = 1'b1;
        nxt_target = ir_ff[10:0];
      end
      `OP_RETURN, `OP_INT_RETURN: begin
        nxt_flags  = 1'b0;
        nxt_two    = 1'b1;
        nxt_pop    = 1'b1;
        nxt_target = stack_mem[sp_ff - SPW'(1)];
      end
      `OP_TAB_RD: begin
        nxt_flags = 1'b0;
        nxt_two   = 1'b1;
        nxt_tab   = 1'b1;
      end
    endcase
    // Destination is the low program counter byte
    if (nxt_wr_mem && mfield == `PC_LOW_ADDR) begin
      nxt_wr_mem = 1'b0;
      nxt_two    = 1'b1;
      nxt_target = {pc_ff[10:8], nxt_res};
    end
  end

  // ==========================================
  // Phase counter and cycle kind
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_ff <= `PH_FETCH;
      cyc_ff   <= CYC_EXEC;
    end else begin
      phase_ff <= phase_ff + 2'd1;
      if (phase_ff == `PH_EXEC) begin
        cyc_ff <= (cyc_ff == CYC_EXEC && nxt_two) ? CYC_EXTRA : CYC_EXEC;
      end
    end
  end

  // ==========================================
  // Fetch, operand read and program counter
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pc_ff      <= `PC_RESET;
      pm_addr_ff <= `PC_RESET;
      target_ff  <= `PC_RESET;
      ir_ff      <= 16'h0000;
      operand_ff <= 8'h00;
      dm_addr_ff <= 8'h00;
      tab_ff     <= 1'b0;
      retire_ff  <= 1'b0;
    end else begin
      retire_ff <= 1'b0;
      if (cyc_ff == CYC_EXEC) begin
        unique case (phase_ff)
          `PH_FETCH: ir_ff      <= pm_data;
          `PH_ADDR:  dm_addr_ff <= ir_ff[7:0];
          // Low counter byte is read from the core, not memory
          `PH_READ:  operand_ff <= (ir_ff[7:0] == `PC_LOW_ADDR) ? pc_ff[7:0] : dm_rdata;
          `PH_EXEC: begin
            target_ff <= nxt_target;
            tab_ff    <= nxt_tab;
            if (nxt_two) begin
              // Sequential word is fetched here and dropped; table read fetches its table word instead
              pm_addr_ff <= nxt_tab ? {`TBL_PAGE, acc_ff} : pc_inc;
            end else begin
              pc_ff      <= pc_inc;
              pm_addr_ff <= pc_inc;
              retire_ff  <= 1'b1;
            end
          end
        endcase
      end else if (phase_ff == `PH_EXEC) begin
        pc_ff      <= tab_ff ? pc_ff + 11'd1 : target_ff;
        pm_addr_ff <= tab_ff ? pc_ff + 11'd1 : target_ff;
        tab_ff     <= 1'b0;
        retire_ff  <= 1'b1;
      end
    end
  end

  // ==========================================
  // Write back: accumulator, flags, data memory
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      acc_ff      <= `ACC_RESET;
      zero_ff     <= 1'b0;
      carry_ff    <= 1'b0;
      dm_wdata_ff <= 8'h00;
      dm_we_ff    <= 1'b0;
    end else begin
      dm_we_ff <= 1'b0;
      if (phase_ff == `PH_EXEC && cyc_ff == CYC_EXEC) begin
        if (nxt_wr_acc) begin
          acc_ff <= nxt_res;
        end
        if (nxt_wr_mem) begin
          dm_wdata_ff <= nxt_res;
          dm_we_ff    <= 1'b1;
        end
        // Each flag moves only for ops that own it
        if (nxt_flags && alu_out[8]) begin
          zero_ff <= (nxt_res == 8'h00);
        end
        if (nxt_flags && alu_out[9]) begin
          carry_ff <= alu_out[10];
        end
      end else if (phase_ff == `PH_READ && cyc_ff == CYC_EXTRA && tab_ff) begin
        dm_wdata_ff <= pm_data[7:0];
      end else if (phase_ff == `PH_EXEC && cyc_ff == CYC_EXTRA && tab_ff) begin
        dm_we_ff <= (dm_addr_ff != `PC_LOW_ADDR);
      end
    end
  end

  // ==========================================
  // Return stack; overflow wraps
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sp_ff <= '0;
    end else if (phase_ff == `PH_EXEC && cyc_ff == CYC_EXEC) begin
      if (nxt_push) begin
        stack_mem[sp_ff] <= pc_inc;
        sp_ff            <= sp_ff + SPW'(1);
      end else if (nxt_pop) begin
        sp_ff <= sp_ff - SPW'(1);
      end
    end
  end

endmodule : instr_cycle_core

// *** sim/mem_model.sv ***
// Purpose: Program and data memory beside the core
// Assumes: Bench loads the program image after time zero
// Notes:   Reads are combinational, as the core expects
`timescale 1ns/10ps

module mem_model (
  // Clock
  input  wire logic        clk,
  // Program side
  input  wire logic [10:0] pm_addr,
  output logic      [15:0] pm_data,
  // Data side
  input  wire logic [7:0]  dm_addr,
  input  wire logic [7:0]  dm_wdata,
  input  wire logic        dm_we,
  output logic      [7:0]  dm_rdata
);
  // ==========================================
  // Storage
  logic [15:0] prog [0:2047];
  logic [7:0]  dmem [0:255];

  initial begin
    for (int i = 0; i < 2048; i++) prog[i] = 16'h0000;
    for (int i = 0; i < 256; i++) dmem[i] = 8'h00;
  end

  assign pm_data  = prog[pm_addr];
  assign dm_rdata = dmem[dm_addr];

  // Write lands at the edge that ends the strobe
  always @(posedge clk) begin
    if (dm_we) begin
      dmem[dm_addr] <= dm_wdata;
    end
  end
endmodule : mem_model

// *** sim/core_properties.sv ***
// Purpose: Timing checks on the core's ports
// Assumes: One clock domain, reset_n synchronous
// Notes:   Bound to every core instance
`timescale 1ns/10ps
`include "core_cfg.svh"

module core_properties
  import core_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Memory side
  input wire logic [10:0] pm_addr_ff,
  input wire logic [7:0]  dm_addr_ff,
  input wire logic        dm_we_ff,
  // Status
  input wire logic [1:0]  phase_ff,
  input wire logic        retire_ff,
  input wire logic [7:0]  acc_ff,
  input wire logic        zero_ff,
  input wire logic        carry_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ==========================================
  // Sequences
  sequence s_rest;
    phase_ff == `PH_ADDR ##1 phase_ff == `PH_READ ##1 phase_ff == `PH_EXEC;
  endsequence
  sequence s_wrap;
    phase_ff == `PH_FETCH;
  endsequence

  // ==========================================
  // Properties
  property p_cycle;
    phase_ff == `PH_FETCH |=> s_rest ##1 s_wrap;
  endproperty
  property p_retire_phase;
    retire_ff |-> phase_ff == `PH_FETCH;
  endproperty
  property p_quiet;
    retire_ff |=> !retire_ff [*3];
  endproperty
  property p_gap;
    retire_ff |-> (##4 retire_ff) or (##8 retire_ff);
  endproperty
  property p_pm_hold;
    phase_ff != `PH_FETCH |-> $stable(pm_addr_ff);
  endproperty
  property p_we;
    dm_we_ff |-> phase_ff == `PH_FETCH && dm_addr_ff != `PC_LOW_ADDR;
  endproperty
  property p_acc;
    $changed(acc_ff) |-> phase_ff == `PH_FETCH;
  endproperty
  property p_flags;
    $changed({zero_ff, carry_ff}) |-> phase_ff == `PH_FETCH;
  endproperty

  a_cycle:        assert property (p_cycle) else $error("phase order broken");
  a_retire_phase: assert property (p_retire_phase) else $error("retire off cycle");
  a_quiet:        assert property (p_quiet) else $error("retire too soon");
  a_gap:          assert property (p_gap) else $error("instruction length wrong");
  a_pm_hold:      assert property (p_pm_hold) else $error("fetch address moved");
  a_we:           assert property (p_we) else $error("bad data write");
  a_acc:          assert property (p_acc) else $error("acc changed mid cycle");
  a_flags:        assert property (p_flags) else $error("flag changed mid cycle");
endmodule : core_properties

bind instr_cycle_core core_properties u_props (
  .clk        (clk),
  .reset_n    (reset_n),
  .pm_addr_ff (pm_addr_ff),
  .dm_addr_ff (dm_addr_ff),
  .dm_we_ff   (dm_we_ff),
  .phase_ff   (phase_ff),
  .retire_ff  (retire_ff),
  .acc_ff     (acc_ff),
  .zero_ff    (zero_ff),
  .carry_ff   (carry_ff)
);

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench for the instruction cycle core
// Assumes: Retire pulse marks the end of each instruction
// Notes:   One program, run once from reset, exercises every scenario
`timescale 1ns/10ps

module tb_top;
  import core_pkg::*;
  // ==========================================
  // Signals
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [10:0] pm_addr;
  logic [15:0] pm_data;
  logic [7:0]  dm_addr;
  logic [7:0]  dm_wdata;
  logic [7:0]  dm_rdata;
  logic        dm_we;
  logic [1:0]  phase;
  logic        retire;
  byte_t       acc;
  logic        zero;
  logic        carry;
  int          bad_count = 0;
  int          comparisons = 0;
  int          ticks = 0;
  logic [15:0] img [0:17] = '{16'h20ff, 16'h3001, 16'h4001, 16'h5010, 16'h7310, 16'h0010,
    16'h1711, 16'h0811, 16'h3081, 16'h5012, 16'h0b12, 16'h0311, 16'h9110, 16'ha010,
    16'h2055, 16'hc040, 16'hc042, 16'hb050};

  always #12.5 clk = ~clk;

  instr_cycle_core dut (
    .clk(clk), .reset_n(reset_n), .pm_addr_ff(pm_addr), .pm_data(pm_data),
    .dm_addr_ff(dm_addr), .dm_wdata_ff(dm_wdata), .dm_we_ff(dm_we), .dm_rdata(dm_rdata),
    .phase_ff(phase), .retire_ff(retire), .acc_ff(acc), .zero_ff(zero), .carry_ff(carry));
  mem_model mem (
    .clk(clk), .pm_addr(pm_addr), .pm_data(pm_data), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_rdata(dm_rdata));

  // ==========================================
  // Helpers
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Waits for the next retire; gap 0 skips the length check
  task automatic step(input int gap, input byte_t acc_exp);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (retire !== 1'b1 && n < 20);
    if (gap != 0) chk("clocks", 8'(gap), 8'(n));
    chk("acc", acc_exp, acc);
  endtask : step

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // ==========================================
  // Scenarios
  task automatic t_arith;
    step(0, 8'hff);
    step(4, 8'h00);
    chk("carry", 8'h01, {7'h00, carry});
    chk("zero", 8'h01, {7'h00, zero});
    step(4, 8'hff);
    chk("borrow", 8'h01, {7'h00, carry});
    step(4, 8'hff);
    step(4, 8'hff);
    step(4, 8'hf7);
    step(4, 8'hf7);
    step(4, 8'h00);
    step(4, 8'h81);
    step(4, 8'h81);
    step(4, 8'h40);
    chk("rot carry", 8'h01, {7'h00, carry});
    step(4, 8'h00);
    chk("and zero", 8'h01, {7'h00, zero});
    chk("bit byte", 8'hf7, mem.dmem[8'h10]);
    chk("inc byte", 8'h01, mem.dmem[8'h11]);
    $display("test arith done");
  endtask : t_arith

  task automatic t_skip;
    step(4, 8'h00);
    step(8, 8'h00);
    $display("test skip done");
  endtask : t_skip

  task automatic t_branch;
    step(8, 8'h00);
    step(4, 8'h33);
    step(8, 8'h33);
    step(8, 8'h33);
    step(8, 8'h33);
    step(8, 8'h33);
    step(4, 8'h02);
    step(8, 8'h02);
    step(4, 8'ha5);
    chk("table byte", 8'ha5, mem.dmem[8'h13]);
    $display("test branch done");
  endtask : t_branch

  task automatic t_pcl;
    step(4, 8'h60);
    step(8, 8'h60);
    step(4, 8'h77);
    $display("test pcl done");
  endtask : t_pcl

  task automatic t_misc;
    step(4, 8'h77);
    step(8, 8'h77);
    step(4, 8'h03);
    chk("rlc carry", 8'h00, {7'h00, carry});
    step(4, 8'h02);
    chk("xor zero", 8'h00, {7'h00, zero});
    chk("set byte", 8'hff, mem.dmem[8'h10]);
    $display("test misc done");
  endtask : t_misc

  // ==========================================
  // Main sequence
  initial begin
    #1;
    for (int i = 0; i < 18; i++) mem.prog[i] = img[i];
    mem.prog[11'h040] = 16'h2033;
    mem.prog[11'h041] = 16'hd000;
    mem.prog[11'h042] = 16'he000;
    mem.prog[11'h050] = 16'h2002;
    mem.prog[11'h051] = 16'hf013;
    mem.prog[11'h052] = 16'h0013;
    mem.prog[11'h053] = 16'h2060;
    mem.prog[11'h054] = 16'h5006;
    mem.prog[11'h055] = 16'h20ee;
    mem.prog[11'h060] = 16'h2077;
    mem.prog[11'h061] = 16'h6310;
    mem.prog[11'h062] = 16'h8014;
    mem.prog[11'h063] = 16'h20ee;
    mem.prog[11'h064] = 16'h0c11;
    mem.prog[11'h065] = 16'h0511;
    mem.prog[11'h066] = 16'hb066;
    mem.prog[11'h702] = 16'h12a5;
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_arith();
    t_skip();
    t_branch();
    t_pcl();
    t_misc();
    wrap_up();
  end

  // Run needs about 160 clocks; the ceiling leaves wide margin
  always @(posedge clk) begin
    ticks++;
    if (ticks == 2000) begin
      bad_count++;
      wrap_up();
    end
  end
endmodule : tb_top
